// ==== act_consts.vh ====
`ifndef ACT_CONSTS_VH
`define ACT_CONSTS_VH
// Register indices; the byte address on the bus is four times the index
`define ACT_IDX_FLAG 8'h0c
`define ACT_IDX_CNT_LO 8'h0e
`define ACT_IDX_CNT_HI 8'h0f
`define ACT_IDX_CTRL 8'h10
`define ACT_IDX_ENABLE 8'h8c
// Control register fields
`define ACT_CTRL_RUN 0
`define ACT_CTRL_SRC 1
`define ACT_CTRL_NOSYNC 2
`define ACT_CTRL_OSC 3
`define ACT_CTRL_PS_LO 4
`define ACT_CTRL_PS_HI 5
`define ACT_CTRL_MASK 8'h3f
`define ACT_CTRL_RESET 8'h00
// Flag and enable registers
`define ACT_OVF_BIT 0
`define ACT_FLAG_RESET 8'h00
`define ACT_ENABLE_RESET 8'h00
`endif

// ==== act_timer.v ====
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/1ps
// What this block does
// - Sync-disable bit counts raw external edges unsynchronised
// - Unsynchronised counting continues during halt
// - Overflow interrupt in unsynchronised mode wakes processor
// - No capture/compare time base when unsynchronised
// - Byte reads while running return valid values
// - Stop counter before writing; write wins increment
// - Counter held as high/low bytes, unreset
// - Control: prescale 5:4, osc 3, sync 2, source 1, run 0
// - Unused bits read zero; control cleared only at power-on
`include "act_consts.vh"

module act_timer #(
   parameter CNT_W = 16,
   parameter PS_W = 3
) (
   input wire clock,
   input wire rst,
   input wire softRst,
   input wire [9:0] avsAddress,
   input wire avsRead,
   input wire avsWrite,
   input wire [31:0] avsWriteData,
   input wire [3:0] avsByteEnable,
   output reg [31:0] avsReadData,
   output wire avsWaitrequest,
   input wire extClkIn,
   input wire sleepIn,
   output wire oscEnable,
   output wire irq,
   output wire wakeReq,
   output reg [CNT_W-1:0] timeBase,
   output wire timeBaseValid
);

   reg ackR_r;
   reg [7:0] ctrl_r;
   reg ovfEnable_r;
   reg [CNT_W-1:0] count_r;
   reg [31:0] readNxt;
   wire ovfFlag;
   wire rawEdge;
   wire syncEdge;
   wire extSync;
   wire psDone;

   wire req = avsRead | avsWrite;
   wire ack = req & ackR_r;
   wire [7:0] idx = avsAddress[9:2];
   wire wrLane = avsWrite & ack & avsByteEnable[0];
   wire [7:0] wrByte = avsWriteData[7:0];
   wire wrCtrl = wrLane & (idx == `ACT_IDX_CTRL);
   wire wrLo = wrLane & (idx == `ACT_IDX_CNT_LO);
   wire wrHi = wrLane & (idx == `ACT_IDX_CNT_HI);
   wire wrEn = wrLane & (idx == `ACT_IDX_ENABLE);
   wire rdFlag = avsRead & ack & (idx == `ACT_IDX_FLAG);

   wire runOn = ctrl_r[`ACT_CTRL_RUN];
   wire extSrc = ctrl_r[`ACT_CTRL_SRC];
   wire noSync = ctrl_r[`ACT_CTRL_NOSYNC];
   wire asyncMode = extSrc & noSync;
   wire [1:0] psSel = {ctrl_r[`ACT_CTRL_PS_HI], ctrl_r[`ACT_CTRL_PS_LO]};

   // Raw edge skips the synchroniser so counting is free of phase clocks
   act_edge_det #(
      .IDLE(1'b0)
   ) u_rawEdge (
      .clock(clock),
      .rst(rst),
      .din(extClkIn),
      .rise(rawEdge)
   );

   act_sync2 u_extSync (
      .clock(clock),
      .rst(rst),
      .din(extClkIn),
      .dout(extSync)
   );

   act_edge_det #(
      .IDLE(1'b0)
   ) u_syncEdge (
      .clock(clock),
      .rst(rst),
      .din(extSync),
      .rise(syncEdge)
   );
   // Synchronised and internal sources stop while the core is halted
   wire srcTick = asyncMode ? rawEdge :
      (sleepIn ? 1'b0 : (extSrc ? syncEdge : 1'b1));
   // Divider restarts on a counter byte write and while stopped
   act_prescaler #(
      .PS_W(PS_W)
   ) u_prescale (
      .clock(clock),
      .rst(rst),
      .clear(wrLo | wrHi | ~runOn),
      .tick(srcTick),
      .sel(psSel),
      .done(psDone)
   );
   wire incr = runOn & srcTick & psDone;
   wire rollover = incr & (&count_r);

   // One wait state: data and write effect land on the edge waitrequest is low
   assign avsWaitrequest = req & ~ackR_r;
   assign oscEnable = ctrl_r[`ACT_CTRL_OSC];
   assign irq = ovfFlag & ovfEnable_r;
   assign wakeReq = irq & sleepIn & asyncMode;
   assign timeBaseValid = ~asyncMode;

   always @* begin
      readNxt = 32'h00000000;
      case (idx)
         `ACT_IDX_FLAG: readNxt[`ACT_OVF_BIT] = ovfFlag;
         `ACT_IDX_ENABLE: readNxt[`ACT_OVF_BIT] = ovfEnable_r;
         // Reads come from the live counter in the clock domain, never torn
         `ACT_IDX_CNT_LO: readNxt[7:0] = count_r[7:0];
         `ACT_IDX_CNT_HI: readNxt[7:0] = count_r[15:8];
         `ACT_IDX_CTRL: readNxt[7:0] = ctrl_r & `ACT_CTRL_MASK;
         default: readNxt = 32'h00000000;
      endcase
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         ackR_r <= 1'b0;
         avsReadData <= 32'h00000000;
      end else begin
         ackR_r <= req & ~ackR_r;
         if (avsRead & ~ackR_r) begin
            avsReadData <= readNxt;
         end
      end
   end

   // Control survives other resets; only power-on clears it
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         ctrl_r <= `ACT_CTRL_RESET;
      end else if (wrCtrl) begin
         ctrl_r <= wrByte & `ACT_CTRL_MASK;
      end
   end

   // Only a flag already returned is cleared, so a set during the wait state survives
   act_sticky u_ovfFlag (
      .clock(clock),
      .rst(rst),
      .softClr(softRst),
      .set(rollover),
      .rdClr(rdFlag & avsReadData[`ACT_OVF_BIT]),
      .flag(ovfFlag)
   );

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         ovfEnable_r <= 1'b0;
      end else if (softRst) begin
         ovfEnable_r <= 1'b0;
      end else if (wrEn) begin
         ovfEnable_r <= wrByte[`ACT_OVF_BIT];
      end
   end

   // No reset: counter bytes are unknown at power-on, kept across resets
   always @(posedge clock) begin
      if (wrLo | wrHi) begin
         // Write wins over a coincident increment, so the result is defined
         if (wrLo) begin
            count_r[7:0] <= wrByte;
         end
         if (wrHi) begin
            count_r[15:8] <= wrByte;
         end
      end else if (incr) begin
         count_r <= count_r + 16'h0001;
      end
   end

   // Time base is offered only while counting synchronised
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         timeBase <= {CNT_W{1'b0}};
      end else if (~asyncMode) begin
         timeBase <= count_r;
      end
   end

endmodule

// Two-flop synchroniser; nothing but the second stage is read outside
module act_sync2 (
   input wire clock,
   input wire rst,
   input wire din,
   output wire dout
);

   reg meta_r;
   reg stage_r;

   assign dout = stage_r;

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         meta_r <= 1'b0;
         stage_r <= 1'b0;
      end else begin
         meta_r <= din;
         stage_r <= meta_r;
      end
   end

endmodule

// Rising-edge detector; history resets to the idle level so reset makes no false edge
module act_edge_det #(
   parameter [0:0] IDLE = 1'b0
) (
   input wire clock,
   input wire rst,
   input wire din,
   output wire rise
);

   reg prev_r;

   assign rise = din & ~prev_r;

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         prev_r <= IDLE;
      end else begin
         prev_r <= din;
      end
   end

endmodule

// Edge divider for ratios 1, 2, 4 and 8; done marks the edge that counts
module act_prescaler #(
   parameter PS_W = 3
) (
   input wire clock,
   input wire rst,
   input wire clear,
   input wire tick,
   input wire [1:0] sel,
   output wire done
);

   reg [PS_W-1:0] count_r;
   reg [PS_W-1:0] limit;
   integer i;

   assign done = (count_r == limit);

   // Limit is 2**sel - 1, built bit by bit to avoid a wide shift result
   always @* begin
      limit = {PS_W{1'b0}};
      for (i = 0; i < PS_W; i = i + 1) begin
         limit[i] = (i < sel);
      end
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         count_r <= {PS_W{1'b0}};
      end else if (clear) begin
         count_r <= {PS_W{1'b0}};
      end else if (tick) begin
         count_r <= done ? {PS_W{1'b0}} : count_r + {{(PS_W-1){1'b0}}, 1'b1};
      end
   end

endmodule

// Sticky event bit; other reset clears it first, then a set beats a read clear
module act_sticky (
   input wire clock,
   input wire rst,
   input wire softClr,
   input wire set,
   input wire rdClr,
   output wire flag
);

   reg flag_r;

   assign flag = flag_r;

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         flag_r <= 1'b0;
      end else if (softClr) begin
         flag_r <= 1'b0;
      end else if (set) begin
         flag_r <= 1'b1;
      end else if (rdClr) begin
         flag_r <= 1'b0;
      end
   end

endmodule

// ==== act_ext_clk_src.sv ====
`timescale 1ns/1ps
module act_ext_clk_src (
   input wire clock,
   input wire run,
   output logic extClk = 1'b0
);
   // Parked low while off, so no stray edge reaches the counter
   always @(posedge clock) begin
      extClk <= run & ~extClk;
   end
endmodule

// ==== act_timer_checker.sv ====
`timescale 1ns/1ps
module act_timer_checker #(parameter CNT_W = 16) (
   input wire clock,
   input wire rst,
   input wire softRst,
   input wire avsRead,
   input wire avsWrite,
   input wire avsWaitrequest,
   input wire sleepIn,
   input wire oscEnable,
   input wire irq,
   input wire wakeReq,
   input wire timeBaseValid,
   input wire [9:0] avsAddress,
   input wire [31:0] avsWriteData,
   input wire [31:0] avsReadData,
   input wire [3:0] avsByteEnable,
   input wire [CNT_W-1:0] timeBase
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   wire req = avsRead | avsWrite;
   wire take = req & ~avsWaitrequest;
   property p_wait; req && avsWaitrequest |=> !avsWaitrequest; endproperty
   a_wait: assert property (p_wait) else $error("late answer");
   property p_rel; take |=> avsWaitrequest || !req; endproperty
   a_rel: assert property (p_rel) else $error("no wait state");
   property p_hi; take && avsRead |-> avsReadData[31:8] == 24'h0; endproperty
   a_hi: assert property (p_hi) else $error("upper bits set");
   property p_osc; take && avsWrite && avsAddress == 10'h040 && avsByteEnable[0]
      |=> oscEnable == $past(avsWriteData[3]); endproperty
   a_osc: assert property (p_osc) else $error("osc bit");
   property p_keep; !avsWrite |=> $stable(oscEnable); endproperty
   a_keep: assert property (p_keep) else $error("control moved");
   property p_soft; softRst && !avsWrite |=> !irq; endproperty
   a_soft: assert property (p_soft) else $error("irq after soft reset");
   property p_tb; !timeBaseValid ##1 !timeBaseValid |-> $stable(timeBase); endproperty
   a_tb: assert property (p_tb) else $error("time base moved");
   property p_wake; wakeReq == (irq && sleepIn && !timeBaseValid); endproperty
   a_wake: assert property (p_wake) else $error("wake mismatch");
   c_wake: cover property (wakeReq);
   c_irq: cover property (irq && !sleepIn);
   c_soft: cover property (softRst);
endmodule
bind act_timer act_timer_checker #(.CNT_W(CNT_W)) u_chk (.clock, .rst, .softRst, .avsRead, .avsWrite,
   .avsWaitrequest, .sleepIn, .oscEnable, .irq, .wakeReq, .timeBaseValid, .avsAddress, .avsWriteData,
   .avsReadData, .avsByteEnable, .timeBase);

// ==== act_timer_tb_top.sv ====
`timescale 1ns/1ps
module act_timer_tb_top;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic softRst = 1'b0, avsRead = 1'b0, avsWrite = 1'b0, sleepIn = 1'b0, extRun = 1'b0;
   logic [9:0] avsAddress = 10'h0;
   logic [31:0] avsWriteData = 32'h0, rdv;
   wire [31:0] avsReadData;
   wire avsWaitrequest, extClkIn, oscEnable, irq, wakeReq, timeBaseValid;
   wire [15:0] timeBase;
   int numErrors = 0, numChecks = 0;
   initial forever #2.5 clock = ~clock;
   act_timer uut (.clock, .rst, .softRst, .avsAddress, .avsRead, .avsWrite, .avsWriteData, .avsByteEnable(4'hf),
      .avsReadData, .avsWaitrequest, .extClkIn, .sleepIn, .oscEnable, .irq, .wakeReq, .timeBase, .timeBaseValid);
   act_ext_clk_src src (.clock, .run(extRun), .extClk(extClkIn));
   task automatic acc(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      avsAddress <= {idx, 2'h0};
      avsWriteData <= {24'h0, wd};
      avsWrite <= w;
      avsRead <= !w;
      do @(posedge clock); while (avsWaitrequest !== 1'b0);
      rdv = avsReadData;
      avsWrite <= 1'b0;
      avsRead <= 1'b0;
      @(posedge clock);
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      numChecks++;
      if (g !== e) begin
         numErrors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic rc(input logic [7:0] idx, input logic [31:0] e);
      acc(1'b0, idx, 8'h0);
      chk($sformatf("reg%h", idx), e, rdv);
   endtask
   task automatic printVerdict;
      $display("checks %0d errors %0d", numChecks, numErrors);
      if (numErrors == 0 && numChecks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      rc(8'h10, 0);
      rc(8'h0c, 0);
      rc(8'h20, 0);
      acc(1, 8'h10, 8'hff);
      chk("osc", 1, oscEnable);
      rc(8'h10, 8'h3f);
      acc(1, 8'h10, 8'h00);
      acc(1, 8'h0e, 8'hfd);
      acc(1, 8'h0f, 8'hff);
      extRun <= 1'b1;
      repeat (20) @(posedge clock);
      rc(8'h0e, 8'hfd);
      rc(8'h0f, 8'hff);
      acc(1, 8'h8c, 8'h01);
      acc(1, 8'h10, 8'h01);
      repeat (4) @(posedge clock);
      chk("irq", 1, irq);
      rc(8'h0c, 1);
      rc(8'h0c, 0);
      acc(1, 8'h10, 8'h06);
      softRst <= 1'b1;
      @(posedge clock);
      softRst <= 1'b0;
      rc(8'h10, 8'h06);
      rc(8'h8c, 0);
      acc(1, 8'h0e, 8'hf8);
      acc(1, 8'h0f, 8'hff);
      acc(1, 8'h8c, 8'h01);
      sleepIn <= 1'b1;
      acc(1, 8'h10, 8'h07);
      wait (wakeReq === 1'b1);
      @(posedge clock);
      chk("tbv", 0, timeBaseValid);
      chk("irq", 1, irq);
      sleepIn <= 1'b0;
      rc(8'h0c, 1);
      acc(1, 8'h10, 8'h00);
      acc(1, 8'h0e, 8'h00);
      acc(1, 8'h0f, 8'h00);
      acc(1, 8'h10, 8'h31);
      repeat (37) @(posedge clock);
      acc(1, 8'h10, 8'h30);
      rc(8'h0f, 0);
      rc(8'h0e, 5);
      rc(8'h0f, 0);
      chk("tb", 5, timeBase);
      chk("tbv", 1, timeBaseValid);
      sleepIn <= 1'b1;
      acc(1, 8'h10, 8'h03);
      repeat (20) @(posedge clock);
      acc(1, 8'h10, 8'h00);
      sleepIn <= 1'b0;
      rc(8'h0e, 5);
      printVerdict;
   end
   // Whole run needs well under a thousand cycles
   initial begin
      #60000;
      numErrors++;
      printVerdict;
   end
endmodule
